// ===== srcs_bank.sv
// Purpose: shared control and status register bank of a four-lane retimer
// Assumes: a serial front end delivers decoded register accesses, one
//          per cycle, with the bus address matched against bus_addr
// Notes:   lane register contents live outside; this block only routes
//
// Summary of operation
// (R1) writes to 0xFF always hit selector
// (R2) enable bit clear routes to shared
// (R3) enable set serves indexed lane set
// (R4) broadcast plus enable writes all lanes
// (R5) read-only bits ignore writes
// (R6) host leaves reserved bits alone
// (R7) host read-modify-writes partial fields
// (R8) strap bits readable, bus address 0x18+strap
// (R9) shared bank soft reset, self-clearing
// (R10) bus master soft reset, self-clearing
// (R11) load inhibit and forced load
// (R12) done flag set after load
// (R13) per-lane interrupt flags readable
// (R14) lane reads use index only
// (R15) selector unreadable, full byte writes
module srcs_bank #(
    parameter logic [7:0] IDENT_VALUE = srcs_pkg::IDENT_DEFAULT  // arbitrary value
) (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic [3:0]                 strap_addr,
    input  wire srcs_pkg::srcs_req_type     req,
    output logic [7:0]                      rdata,
    output logic                            rdata_from_lane,
    output logic [6:0]                      bus_addr,
    output srcs_pkg::srcs_lane_req_type     lane_req,
    input  wire logic                       cfg_load_done,
    input  wire logic [3:0]                 lane_event,
    output logic                            master_reset,
    output logic                            cfg_load_start,
    output logic                            cfg_load_inhibit
);
    logic        sel_hit;         // access names the selector
    logic        to_lanes;        // access goes to lane sets
    logic [7:0]  sel_value;       // selector contents (not readable)
    logic [3:0]  strap_q;         // strap sampled every clock
    logic [7:0]  rstctl;          // reset and load control
    logic [7:0]  status_rw;       // writable part of status register
    logic [7:0]  rsv2;            // reserved, held as storage
    logic [7:0]  rsv6;            // reserved, held as storage
    logic [7:0]  rsv7;            // reserved, held as storage
    logic        load_done;       // configuration load complete
    logic [3:0]  lane_irq;        // per-lane sticky flags
    logic        bank_clear;      // shared soft reset pulse
    logic        shared_wr;       // write to the shared set
    logic        force_prev;      // force bit last cycle
    logic [7:0]  status_view;     // status as read
    logic [7:0]  next_rdata;      // read mux result

    srcs_selector u_sel (
        .mclk      (mclk),
        .rst       (rst),
        .req       (req),
        .sel_hit   (sel_hit),
        .to_lanes  (to_lanes),
        .lane_req  (lane_req),
        .sel_value (sel_value)
    );

    srcs_status u_stat (
        .mclk            (mclk),
        .rst             (rst),
        .bank_clear      (bank_clear),
        .load_start      (cfg_load_start),
        .load_done_pulse (cfg_load_done),
        .lane_event      (lane_event),
        .load_done       (load_done),
        .lane_irq        (lane_irq)
    );

    // shared write only when not routed to lanes and not the selector
    assign shared_wr  = req.wr && !to_lanes && !sel_hit;
    // (R9) soft reset pulse
    assign bank_clear = rstctl[srcs_pkg::BIT_BANK_RESET];
    // (R10) master reset pulse
    assign master_reset = rstctl[srcs_pkg::BIT_MASTER_RST];
    // (R11) inhibit drives loader
    assign cfg_load_inhibit = status_rw[srcs_pkg::BIT_LOAD_INHIB];
    // (R11) force bit rising edge starts a load unless inhibited
    assign cfg_load_start = rstctl[srcs_pkg::BIT_FORCE_LOAD] && !force_prev
                            && !cfg_load_inhibit;
    // (R8) bus address from strap
    assign bus_addr = srcs_pkg::BUS_ADDR_BASE + {3'h0, strap_q};

    // strap captured by the clock, never by the reset itself
    always_ff @(posedge mclk) begin
        strap_q <= strap_addr;
    end

    // reset and load control; the two reset bits last one cycle
    always_ff @(posedge mclk) begin
        if (rst || bank_clear) begin
            rstctl     <= srcs_pkg::RST_RSTCTL;
            force_prev <= 1'b0;
        end else begin
            force_prev <= rstctl[srcs_pkg::BIT_FORCE_LOAD];
            if (shared_wr && req.addr == srcs_pkg::OFS_RSTCTL) begin
                rstctl <= req.wdata;
            end else begin
                // (R9) bits self-clear
                rstctl <= rstctl & srcs_pkg::MASK_RSTCTL;
            end
        end
    end

    // writable storage of the shared set
    always_ff @(posedge mclk) begin
        if (rst || bank_clear) begin
            status_rw <= srcs_pkg::RST_STATUS & srcs_pkg::MASK_STATUS;
            rsv2      <= srcs_pkg::RST_RSV2;
            rsv6      <= srcs_pkg::RST_RSV6;
            rsv7      <= srcs_pkg::RST_RSV7;
        end else if (shared_wr) begin
            // (R5) read-only fields masked
            if (req.addr == srcs_pkg::OFS_STATUS) begin
                status_rw <= req.wdata & srcs_pkg::MASK_STATUS;
            end
            if (req.addr == srcs_pkg::OFS_RSV2) begin
                rsv2 <= req.wdata;
            end
            if (req.addr == srcs_pkg::OFS_RSV6) begin
                rsv6 <= req.wdata;
            end
            if (req.addr == srcs_pkg::OFS_RSV7) begin
                rsv7 <= req.wdata;
            end
        end
    end

    // (R13) flag bit order
    // (R12) done bit placed
    assign status_view = status_rw
                       | {3'h0, load_done, lane_irq[0], lane_irq[1],
                          lane_irq[2], lane_irq[3]};

    // read mux for the shared set; unmapped offsets read zero
    always_comb begin
        unique case (req.addr)
            srcs_pkg::OFS_STRAP:  next_rdata = {strap_q, 4'h0};
            srcs_pkg::OFS_IDENT:  next_rdata = IDENT_VALUE;
            srcs_pkg::OFS_RSV2:   next_rdata = rsv2;
            srcs_pkg::OFS_RSV3:   next_rdata = 8'h00;
            srcs_pkg::OFS_RSTCTL: next_rdata = rstctl;
            srcs_pkg::OFS_STATUS: next_rdata = status_view;
            srcs_pkg::OFS_RSV6:   next_rdata = rsv6;
            srcs_pkg::OFS_RSV7:   next_rdata = rsv7;
            // (R15) selector not readable
            srcs_pkg::OFS_SELECT: next_rdata = srcs_pkg::SELECT_READ_VALUE;
            default:              next_rdata = 8'h00;
        endcase
    end

    // registered read data; lane reads are answered by the lane sets
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata           <= 8'h00;
            rdata_from_lane <= 1'b0;
        end else if (req.rd) begin
            rdata           <= to_lanes ? 8'h00 : next_rdata;
            rdata_from_lane <= to_lanes;
        end
    end
endmodule

// ===== srcs_bank_asserts.sv
// Purpose: port checks of the shared register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only the ports; lane contents are not modelled
module srcs_bank_asserts (
    input wire logic                        mclk,
    input wire logic                        rst,
    input wire logic [3:0]                  strap_addr,
    input wire srcs_pkg::srcs_req_type      req,
    input wire logic [7:0]                  rdata,
    input wire logic                        rdata_from_lane,
    input wire logic [6:0]                  bus_addr,
    input wire srcs_pkg::srcs_lane_req_type lane_req,
    input wire logic                        cfg_load_done,
    input wire logic [3:0]                  lane_event,
    input wire logic                        master_reset,
    input wire logic                        cfg_load_start,
    input wire logic                        cfg_load_inhibit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_sel_no_lane: assert property (req.wr && req.addr == 8'hFF |-> lane_req.wr_lanes == 4'h0)
        else $error("selector write leaked to lanes");
    a_lane_wr_cause: assert property (lane_req.wr_lanes != 4'h0 |-> req.wr)
        else $error("lane write without host write");
    a_bcast_shape: assert property (lane_req.wr_lanes inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF})
        else $error("lane write pattern illegal");
    a_lane_rd_cause: assert property (lane_req.rd |-> req.rd)
        else $error("lane read without host read");
    a_rd_flag_next: assert property (req.rd |=> rdata_from_lane == $past(lane_req.rd))
        else $error("read source flag wrong");
    a_lane_rdata_zero: assert property (rdata_from_lane |-> rdata == 8'h00)
        else $error("lane read left shared data");
    a_sel_read_zero: assert property (req.rd && req.addr == 8'hFF |=> rdata == 8'h00)
        else $error("selector read not zero");
    a_strap_sum: assert property (!$past(rst) |-> bus_addr == 7'h18 + {3'h0, $past(strap_addr)})
        else $error("bus address not base plus strap");
    a_master_pulse: assert property (master_reset |=> !master_reset)
        else $error("master reset longer than a cycle");
    a_load_pulse: assert property (cfg_load_start |-> !cfg_load_inhibit ##1 !cfg_load_start)
        else $error("load start bad");
endmodule

bind srcs_bank srcs_bank_asserts srcs_bank_asserts_i (
    .mclk(mclk), .rst(rst), .strap_addr(strap_addr), .req(req), .rdata(rdata),
    .rdata_from_lane(rdata_from_lane), .bus_addr(bus_addr), .lane_req(lane_req),
    .cfg_load_done(cfg_load_done), .lane_event(lane_event), .master_reset(master_reset),
    .cfg_load_start(cfg_load_start), .cfg_load_inhibit(cfg_load_inhibit));

// ===== srcs_bank_bench.sv
// Purpose: self-checking bench of the shared register bank
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   lane reads return zero data at the bank's own port
module srcs_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] strap_addr = 4'h9;
    logic [3:0] lane_event = 4'h0;
    srcs_pkg::srcs_req_type req = '0;
    srcs_pkg::srcs_lane_req_type lane_req;
    logic [7:0] rdata, load_count, mreset_count, v, la, lw;
    logic [6:0] bus_addr;
    logic rdata_from_lane, done, mres, start, inhib, lrd;
    logic [3:0] wl;
    logic [1:0] lrl;
    int errors = 0;
    int check_count = 0;
    logic [7:0] sel_tab [9] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h0F};

    srcs_bank srcs_bank_i (.mclk(mclk), .rst(rst), .strap_addr(strap_addr), .req(req),
        .rdata(rdata), .rdata_from_lane(rdata_from_lane), .bus_addr(bus_addr),
        .lane_req(lane_req), .cfg_load_done(done), .lane_event(lane_event),
        .master_reset(mres), .cfg_load_start(start), .cfg_load_inhibit(inhib));
    srcs_loader_model srcs_loader_model_i (.mclk(mclk), .rst(rst), .cfg_load_start(start),
        .master_reset(mres), .cfg_load_done(done), .load_count(load_count),
        .mreset_count(mreset_count));

    initial forever #5 mclk = ~mclk;

    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        check_count++;
        if (got !== ex) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // one-cycle write; lane targets captured while it stands
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        #1 wl = lane_req.wr_lanes;
        la = lane_req.addr;
        lw = lane_req.wdata;
        @(posedge mclk) #1 req = '0;
    endtask

    // one-cycle read; data is settled one edge after it is taken
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge mclk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #1 lrd = lane_req.rd;
        lrl = lane_req.rd_lane;
        @(posedge mclk) #1 req = '0;
        @(posedge mclk) #1 chk("rdata", ex, rdata);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        rd(8'h00, 8'h90);
        chk("bus_addr", 8'h21, {1'b0, bus_addr});
        rd(8'h04, 8'h01);
        rd(8'h05, 8'h10);
        wr(8'h01, 8'h00);
        rd(8'h01, srcs_pkg::IDENT_DEFAULT);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h90);
        wr(8'h05, 8'h1F);
        rd(8'h05, 8'h10);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) #1 lane_event = 4'h1 << i;
            @(posedge mclk) #1 lane_event = 4'h0;
            rd(8'h05, 8'h20 - (8'h08 >> i));
        end
        wr(8'h05, 8'h80);
        chk("inhibit", 8'h01, {7'h0, inhib});
        wr(8'h04, 8'h11);
        rd(8'h04, 8'h11);
        chk("loads", 8'h00, load_count);
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h04, 8'h11);
        rd(8'h05, 8'h0F);
        repeat (10) @(posedge mclk);
        rd(8'h05, 8'h1F);
        chk("loads", 8'h01, load_count);
        wr(8'h04, 8'h21);
        rd(8'h04, 8'h01);
        chk("master", 8'h01, mreset_count);
        wr(8'h02, 8'h5A);
        rd(8'h02, 8'h5A);
        // bank soft reset (bit 6) restores the shared set: RSTCTL 0x01, RSV2 zero, RSV7 0x05
        wr(8'h04, 8'h41);
        rd(8'h04, 8'h01);
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h10);
        rd(8'h07, 8'h05);
        // every documented selector value, write then read through it
        for (int i = 0; i < 9; i++) begin
            v = sel_tab[i];
            wr(8'hFF, v);
            chk("sel_lanes", 8'h00, {4'h0, wl});
            wr(8'h00, 8'h5A);
            chk("wr_lanes", {4'h0, !v[2] ? 4'h0 : v[3] ? 4'hF : 4'h1 << v[1:0]}, {4'h0, wl});
            chk("lane_addr", 8'h00, la);
            chk("lane_wdata", 8'h5A, lw);
            rd(8'h00, v[2] ? 8'h00 : 8'h90);
            chk("lane_rd", {7'h0, v[2]}, {7'h0, lrd});
            chk("from_lane", {7'h0, v[2]}, {7'h0, rdata_from_lane});
            if (v[2]) chk("rd_lane", {6'h0, v[1:0]}, {6'h0, lrl});
        end
        // mid-run reset with lanes selected: routing must fall back to shared
        @(posedge mclk) #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        rd(8'h00, 8'h90);
        rd(8'h05, 8'h10);
        wr(8'hFF, 8'h00);
        rd(8'hFF, 8'h00);
        rd(8'h00, 8'h90);
        // a new strap value must reach both readout and bus address
        @(posedge mclk) #1 strap_addr = 4'h6;
        rd(8'h00, 8'h60);
        chk("bus_addr", 8'h1E, {1'b0, bus_addr});
        tally_and_finish;
    end

    // cuts a hang well past the expected two hundred or fewer cycles
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        tally_and_finish;
    end
endmodule

// ===== srcs_loader_model.sv
// Purpose: configuration loader model standing behind the bank
// Assumes: one load request pulse per load, single core clock
// Notes:   answers after LAT cycles; a master reset aborts a load
module srcs_loader_model #(
    parameter int LAT = 6  // load time in cycles
) (
    input  wire logic  mclk,
    input  wire logic  rst,
    input  wire logic  cfg_load_start,
    input  wire logic  master_reset,
    output logic       cfg_load_done,
    output logic [7:0] load_count,
    output logic [7:0] mreset_count
);
    logic [3:0] wait_cnt;  // cycles left in the running load

    // done pulse is the last count of a load
    assign cfg_load_done = (wait_cnt == 4'h1);

    // a master reset wins over a load in flight
    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_cnt     <= 4'h0;
            load_count   <= 8'h00;
            mreset_count <= 8'h00;
        end else begin
            if (master_reset)
                wait_cnt <= 4'h0;
            else if (cfg_load_start)
                wait_cnt <= 4'(LAT);
            else if (wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
            load_count   <= load_count + 8'(cfg_load_start);
            mreset_count <= mreset_count + 8'(master_reset);
        end
    end
endmodule

// ===== srcs_pkg.sv
// Purpose: shared constants and carrier types for the shared register bank
// Assumes: 8-bit register addresses and data, single core clock
// Notes:   offsets, bit positions and reset values are named once here
package srcs_pkg;
    // register offsets
    localparam logic [7:0] OFS_STRAP    = 8'h00;
    localparam logic [7:0] OFS_IDENT    = 8'h01;
    localparam logic [7:0] OFS_RSV2     = 8'h02;
    localparam logic [7:0] OFS_RSV3     = 8'h03;
    localparam logic [7:0] OFS_RSTCTL   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h05;
    localparam logic [7:0] OFS_RSV6     = 8'h06;
    localparam logic [7:0] OFS_RSV7     = 8'h07;
    localparam logic [7:0] OFS_SELECT   = 8'hFF;
    // field positions
    localparam int BIT_BANK_RESET  = 6;
    localparam int BIT_MASTER_RST  = 5;
    localparam int BIT_FORCE_LOAD  = 4;
    localparam int BIT_LOAD_INHIB  = 7;
    localparam int BIT_LOAD_DONE   = 4;
    localparam int BIT_BCAST       = 3;
    localparam int BIT_LANE_EN     = 2;
    // reset values
    localparam logic [7:0] RST_RSTCTL  = 8'h01;
    localparam logic [7:0] RST_STATUS  = 8'h10;
    localparam logic [7:0] RST_RSV2    = 8'h00;
    localparam logic [7:0] RST_RSV6    = 8'h00;
    localparam logic [7:0] RST_RSV7    = 8'h05;
    localparam logic [7:0] RST_SELECT  = 8'h00;
    // kept-bit mask of RSTCTL (self-clearing bits 5, 6 zero), writable mask of STATUS
    localparam logic [7:0] MASK_RSTCTL = 8'h9F;
    localparam logic [7:0] MASK_STATUS = 8'hE0;
    // bus address base for strapped address
    localparam logic [6:0] BUS_ADDR_BASE = 7'h18;
    // value returned when the selector is read
    localparam logic [7:0] SELECT_READ_VALUE = 8'h00;
    // arbitrary neutral identity value
    localparam logic [7:0] IDENT_DEFAULT = 8'hA5;

    // one register access from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srcs_req_type;

    // access toward the lane register sets
    typedef struct packed {
        logic [3:0] wr_lanes;
        logic       rd;
        logic [1:0] rd_lane;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srcs_lane_req_type;
endpackage

// ===== srcs_selector.sv
// Purpose: register-set selector register and routing decode
// Assumes: one access per cycle from the front end
// Notes:   the selector is write-only; reads are answered by the bank
module srcs_selector (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire srcs_pkg::srcs_req_type     req,
    output logic                            sel_hit,
    output logic                            to_lanes,
    output srcs_pkg::srcs_lane_req_type     lane_req,
    output logic [7:0]                      sel_value
);
    logic [7:0] select_reg;    // selector contents
    logic       lane_en;       // lane bank enable
    logic       bcast;         // broadcast write bit
    logic [1:0] lane_index;    // target lane

    assign lane_en    = select_reg[srcs_pkg::BIT_LANE_EN];
    assign bcast      = select_reg[srcs_pkg::BIT_BCAST];
    assign lane_index = select_reg[1:0];
    // (R1) selector address decode
    assign sel_hit    = req.addr == srcs_pkg::OFS_SELECT;
    // (R2) shared unless enabled
    assign to_lanes   = lane_en && !sel_hit;
    assign sel_value  = select_reg;

    // (R3) indexed lane target
    // (R4) broadcast to all lanes
    assign lane_req.wr_lanes = !(to_lanes && req.wr) ? 4'h0 :
                               bcast ? 4'hF : 4'(4'h1 << lane_index);
    // (R14) reads from one lane
    assign lane_req.rd      = to_lanes && req.rd;
    assign lane_req.rd_lane = lane_index;
    assign lane_req.addr    = req.addr;
    assign lane_req.wdata   = req.wdata;

    // selector update; the shared bank reset leaves it alone so the
    // host does not lose its routing mid-sequence
    always_ff @(posedge mclk) begin
        if (rst) begin
            select_reg <= srcs_pkg::RST_SELECT;
        end else if (req.wr && sel_hit) begin
            // (R15) whole byte stored
            select_reg <= req.wdata;
        end
    end
endmodule

// ===== srcs_status.sv
// Purpose: configuration load done flag and per-lane interrupt flags
// Assumes: lane events and load completion are one-cycle pulses
// Notes:   flags are read-only; lane flags clear on reset or bank_clear, the done flag clears when a load starts
module srcs_status (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       bank_clear,
    input  wire logic       load_start,
    input  wire logic       load_done_pulse,
    input  wire logic [3:0] lane_event,
    output logic            load_done,
    output logic [3:0]      lane_irq
);
    // done flag: low while a load runs, high once it ends
    always_ff @(posedge mclk) begin
        if (rst || bank_clear) begin
            load_done <= 1'b1;
        end else if (load_done_pulse) begin
            // (R12) completion sets flag
            load_done <= 1'b1;
        end else if (load_start) begin
            load_done <= 1'b0;
        end
    end

    // sticky lane flags; lane_irq[0] is lane 0
    always_ff @(posedge mclk) begin
        if (rst) begin
            lane_irq <= 4'h0;
        end else if (bank_clear) begin
            // an event in the clearing cycle wins, so no interrupt is lost
            lane_irq <= lane_event;
        end else begin
            // (R13) latch lane events
            lane_irq <= lane_irq | lane_event;
        end
    end
endmodule
